/* File: verilog/mpo_top.sv */
`timescale 1ns/1ps
`default_nettype none

module mpo_top (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         reset_n,
  // Register port
  input  wire logic [mpo_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [7:0]                   reg_rdata,
  // Compare PWM, events and operating mode from the motor core
  input  wire mpo_pkg::mpo_phase_t          compare_pwm,
  input  wire mpo_pkg::mpo_event_t          core_event,
  input  wire mpo_pkg::mpo_mode_t           core_mode,
  input  wire logic                         pwm_off_start,
  // Pins
  output logic                              phase_u_pulse_pin,
  output logic                              phase_v_pulse_pin,
  output logic                              phase_w_pulse_pin,
  output logic                              commutation_demag_monitor_pin,
  output logic                              zero_cross_monitor_pin,
  // Off-time state toward the PWM core
  output logic                              min_off_hold
);

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // The status word has its own offset so that software can watch the off-time
  // engine without touching the control byte; it is read-only and writes to it
  // are dropped.
  logic ctl_sel;
  logic status_sel;
  logic ctl_wr;
  logic ctl_rd;
  logic status_rd;

  assign ctl_sel    = (reg_addr == mpo_pkg::OFS_CONTROL);
  assign status_sel = (reg_addr == mpo_pkg::OFS_STATUS);
  assign ctl_wr     = reg_wr & ctl_sel;
  assign ctl_rd     = reg_rd & ctl_sel;
  assign status_rd  = reg_rd & status_sel;

  // ---------------------------------------------------------------------------
  // Core mode and events
  // ---------------------------------------------------------------------------
  // The motor core drives these on this clock, so they are used as they come,
  // with no synchroniser and no extra latency in the way.
  logic       mode_switched;
  logic       mode_speed;
  logic       mode_sensor;
  logic       mode_on_sample;
  logic [3:0] mode_delay;
  logic       ev_commutation;
  logic       ev_demag;
  logic       ev_zero_cross;
  logic       ev_speed_capture;

  assign mode_switched    = core_mode.switched_mode;
  assign mode_speed       = core_mode.speed_measure_mode;
  assign mode_sensor      = core_mode.sensor_mode_select;
  assign mode_on_sample   = core_mode.on_time_sampling_enable;
  assign mode_delay       = core_mode.on_time_sample_delay;
  assign ev_commutation   = core_event.commutation;
  assign ev_demag         = core_event.demag;
  assign ev_zero_cross    = core_event.zero_cross;
  assign ev_speed_capture = core_event.speed_capture;

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  logic [7:0] pwm_route_offtime_control_q;
  logic [7:0] pwm_route_offtime_control_d;
  logic       debug_event_mirror_enable;
  logic       phase_u_pulse_route_enable;
  logic       phase_v_pulse_route_enable;
  logic       phase_w_pulse_route_enable;
  logic [3:0] off_time_select;

  always_comb begin
    pwm_route_offtime_control_d = pwm_route_offtime_control_q;
    if (ctl_wr) begin
      pwm_route_offtime_control_d = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pwm_route_offtime_control_q <= mpo_pkg::CONTROL_RESET;
    end else begin
      pwm_route_offtime_control_q <= pwm_route_offtime_control_d;
    end
  end

  assign debug_event_mirror_enable  = pwm_route_offtime_control_q[mpo_pkg::BIT_DEBUG];
  assign phase_w_pulse_route_enable = pwm_route_offtime_control_q[mpo_pkg::BIT_ROUTE_W];
  assign phase_v_pulse_route_enable = pwm_route_offtime_control_q[mpo_pkg::BIT_ROUTE_V];
  assign phase_u_pulse_route_enable = pwm_route_offtime_control_q[mpo_pkg::BIT_ROUTE_U];
  assign off_time_select =
    pwm_route_offtime_control_q[mpo_pkg::OFF_CODE_LSB +: mpo_pkg::OFF_CODE_W];

  // ---------------------------------------------------------------------------
  // Minimum off time
  // ---------------------------------------------------------------------------
  logic off_allow;
  logic off_hold;

  always_comb begin
    off_allow = 1'b1;
    if (mode_sensor) begin
      off_allow = 1'b0;
    end
    if (mode_on_sample) begin
      off_allow = 1'b0;
    end
    if (mode_delay != 4'h0) begin
      off_allow = 1'b0;
    end
  end

  mpo_offtime_timer #(
    .CNT_W    (mpo_pkg::OFF_CNT_W),
    .STEP_CYC (mpo_pkg::OFF_STEP_CYC)
  ) u_offtime (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .start   (pwm_off_start),
    .allow   (off_allow),
    .code    (off_time_select),
    .hold    (off_hold)
  );

  // ---------------------------------------------------------------------------
  // Operating mode qualification
  // ---------------------------------------------------------------------------
  // Speed measurement wins over switched operation when the core reports both,
  // so the monitor pins never carry a mix of the two event sets.
  logic mirror_speed;
  logic mirror_switched;

  assign mirror_speed    = debug_event_mirror_enable & mode_speed;
  assign mirror_switched = debug_event_mirror_enable & ~mode_speed & mode_switched;

  // ---------------------------------------------------------------------------
  // Phase pulse routing
  // ---------------------------------------------------------------------------
  // Outputs are registered so that the pins never glitch on decode logic; this
  // costs one cycle of latency on every routed edge.
  logic pin_u_q;
  logic pin_v_q;
  logic pin_w_q;
  logic pin_u_d;
  logic pin_v_d;
  logic pin_w_d;

  always_comb begin
    pin_u_d = compare_pwm.u & phase_u_pulse_route_enable;
    pin_v_d = compare_pwm.v & phase_v_pulse_route_enable;
    pin_w_d = compare_pwm.w & phase_w_pulse_route_enable;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_u_q <= 1'b0;
      pin_v_q <= 1'b0;
      pin_w_q <= 1'b0;
    end else begin
      pin_u_q <= pin_u_d;
      pin_v_q <= pin_v_d;
      pin_w_q <= pin_w_d;
    end
  end

  assign phase_u_pulse_pin = pin_u_q;
  assign phase_v_pulse_pin = pin_v_q;
  assign phase_w_pulse_pin = pin_w_q;

  // ---------------------------------------------------------------------------
  // Debug event mirror
  // ---------------------------------------------------------------------------
  // Events are mirrored level for level, one cycle late; commutation and demagnetisation
  // share one pin, so a scope cannot tell them apart when they coincide.
  logic mon_cd_q;
  logic mon_z_q;
  logic mon_cd_d;
  logic mon_z_d;

  always_comb begin
    mon_cd_d = 1'b0;
    mon_z_d  = 1'b0;
    if (mirror_speed) begin
      mon_cd_d = ev_commutation;
      mon_z_d  = ev_speed_capture;
    end else if (mirror_switched) begin
      mon_cd_d = ev_commutation | ev_demag;
      mon_z_d  = ev_zero_cross;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mon_cd_q <= 1'b0;
      mon_z_q  <= 1'b0;
    end else begin
      mon_cd_q <= mon_cd_d;
      mon_z_q  <= mon_z_d;
    end
  end

  assign commutation_demag_monitor_pin = mon_cd_q;
  assign zero_cross_monitor_pin        = mon_z_q;

  // ---------------------------------------------------------------------------
  // Off-time state toward the PWM core
  // ---------------------------------------------------------------------------
  // The registered copy trails the internal count by one cycle; the PWM core
  // must allow for that cycle when it decides to switch back on.
  logic hold_q;
  logic hold_d;

  always_comb begin
    hold_d = off_hold;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
    end
  end

  assign min_off_hold = hold_q;

  // ---------------------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------------------
  // The status word shows the internal count, one cycle ahead of the pin, and
  // whether the current mode lets a minimum off time apply at all.
  logic [7:0] status_word;

  always_comb begin
    status_word                         = 8'h00;
    status_word[mpo_pkg::BIT_OFF_HOLD]  = off_hold;
    status_word[mpo_pkg::BIT_OFF_APPLY] = off_allow;
  end

  // ---------------------------------------------------------------------------
  // Control readback
  // ---------------------------------------------------------------------------
  // Readback is rebuilt from the decoded fields, so a field that moves in the
  // package moves in the read data as well.
  logic [7:0] ctl_readback;

  always_comb begin
    ctl_readback                                               = 8'h00;
    ctl_readback[mpo_pkg::BIT_DEBUG]                           = debug_event_mirror_enable;
    ctl_readback[mpo_pkg::BIT_ROUTE_W]                         = phase_w_pulse_route_enable;
    ctl_readback[mpo_pkg::BIT_ROUTE_V]                         = phase_v_pulse_route_enable;
    ctl_readback[mpo_pkg::BIT_ROUTE_U]                         = phase_u_pulse_route_enable;
    ctl_readback[mpo_pkg::OFF_CODE_LSB +: mpo_pkg::OFF_CODE_W] = off_time_select;
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  // Read data stand for one cycle and fall back to zero, so a stale byte can
  // never be mistaken for a fresh read.
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    if (ctl_rd) begin
      rdata_d = ctl_readback;
    end else if (status_rd) begin
      rdata_d = status_word;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : mpo_top

`default_nettype wire

/* File: verilog/mpo_pkg.sv */

package mpo_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W         = 2;
  localparam logic [1:0]  OFS_CONTROL    = 2'h0;
  localparam logic [1:0]  OFS_STATUS     = 2'h1;
  localparam logic [7:0]  CONTROL_RESET  = 8'h00;

  // Field positions of the control register.
  localparam int unsigned BIT_DEBUG      = 7;
  localparam int unsigned BIT_ROUTE_W    = 6;
  localparam int unsigned BIT_ROUTE_V    = 5;
  localparam int unsigned BIT_ROUTE_U    = 4;
  localparam int unsigned OFF_CODE_LSB   = 0;
  localparam int unsigned OFF_CODE_W     = 4;

  // Field positions of the status register.
  localparam int unsigned BIT_OFF_HOLD   = 0;
  localparam int unsigned BIT_OFF_APPLY  = 1;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS  = 20000;
  localparam int unsigned PERIPH_HZ      = 4000000;
  localparam int unsigned PERIPH_PER_STEP = 10;
  // One off-time step in picoseconds: ten peripheral periods, 2.5 us at 4 MHz.
  localparam int unsigned OFF_STEP_PS    = (1000000 / (PERIPH_HZ / 1000000)) * PERIPH_PER_STEP;
  // Least time, so rounded up to whole reference cycles.
  localparam int unsigned OFF_STEP_CYC   = (OFF_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned OFF_CNT_W      = 12;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic w;
    logic v;
    logic u;
  } mpo_phase_t;

  typedef struct packed {
    logic commutation;
    logic demag;
    logic zero_cross;
    logic speed_capture;
  } mpo_event_t;

  typedef struct packed {
    logic       switched_mode;
    logic       speed_measure_mode;
    logic       sensor_mode_select;
    logic       on_time_sampling_enable;
    logic [3:0] on_time_sample_delay;
  } mpo_mode_t;

endpackage : mpo_pkg

/* File: verilog/mpo_offtime_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module mpo_offtime_timer #(
  parameter int unsigned CNT_W    = mpo_pkg::OFF_CNT_W,
  parameter int unsigned STEP_CYC = mpo_pkg::OFF_STEP_CYC
) (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         reset_n,
  // Control
  input  wire logic                         start,
  input  wire logic                         allow,
  input  wire logic [mpo_pkg::OFF_CODE_W-1:0] code,
  // State
  output logic                              hold
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] load_val;

  assign load_val = CNT_W'(({{(CNT_W-mpo_pkg::OFF_CODE_W){1'b0}}, code} + CNT_W'(1)) * CNT_W'(STEP_CYC));

  always_comb begin
    cnt_d = cnt_q;
    if (!allow) begin
      cnt_d = '0;
    end else if (start) begin
      cnt_d = load_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign hold = (cnt_q != '0);

endmodule : mpo_offtime_timer

`default_nettype wire

/* File: tb/mpo_props.sv */
`timescale 1ns/1ps
`default_nettype none
module mpo_props (
  // Clock, reset and register port
  input wire logic                       ref_clk,
  input wire logic                       reset_n,
  input wire logic [mpo_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0]                 reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [7:0]                 reg_rdata,
  // Core side
  input wire mpo_pkg::mpo_phase_t        compare_pwm,
  input wire mpo_pkg::mpo_event_t        core_event,
  input wire mpo_pkg::mpo_mode_t         core_mode,
  input wire logic                       pwm_off_start,
  // Pins
  input wire logic                       phase_u_pulse_pin,
  input wire logic                       phase_v_pulse_pin,
  input wire logic                       phase_w_pulse_pin,
  input wire logic                       commutation_demag_monitor_pin,
  input wire logic                       zero_cross_monitor_pin,
  input wire logic                       min_off_hold
);
  logic [7:0]  ctl_q, ctl_d;
  logic [11:0] run_q, run_d, len_q, len_d;
  logic        ok, cd_e, zc_e;
  // Restarting or dropping the mode mid-hold is out of scope for the length check.
  assign ok = !core_mode.sensor_mode_select && !core_mode.on_time_sampling_enable
              && core_mode.on_time_sample_delay == 4'h0;
  assign cd_e = ctl_q[7] && (core_mode.speed_measure_mode ? core_event.commutation
                : core_mode.switched_mode && (core_event.commutation || core_event.demag));
  assign zc_e = ctl_q[7] && (core_mode.speed_measure_mode ? core_event.speed_capture
                : core_mode.switched_mode && core_event.zero_cross);
  always_comb begin
    ctl_d = (reg_wr && reg_addr == 2'h0) ? reg_wdata : ctl_q;
    run_d = min_off_hold ? run_q + 12'h001 : 12'h000;
    len_d = (pwm_off_start && ok) ? 12'h07d * ({8'h00, ctl_q[3:0]} + 12'h001) : len_q;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= 8'h00;
      run_q <= 12'h000;
      len_q <= 12'h000;
    end else begin
      ctl_q <= ctl_d;
      run_q <= run_d;
      len_q <= len_d;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_route_u_pin:
    assert property (phase_u_pulse_pin == $past(compare_pwm.u && ctl_q[4])) else $error("phase U pin wrong");
  a_route_v_pin:
    assert property (compare_pwm.v && ctl_q[5] |=> phase_v_pulse_pin) else $error("phase V pin low");
  a_route_w_pin:
    assert property (!(compare_pwm.w && ctl_q[6]) |=> !phase_w_pulse_pin) else $error("phase W pin leaked");
  a_mirror_cd_pin:
    assert property (commutation_demag_monitor_pin == $past(cd_e)) else $error("monitor pin one wrong");
  a_mirror_zc_pin:
    assert property (zero_cross_monitor_pin == $past(zc_e)) else $error("monitor pin two wrong");
  a_read_ctl_back:
    assert property (reg_rd && reg_addr == 2'h0 |=> reg_rdata == $past(ctl_q)) else $error("control readback");
  a_read_idle_zero:
    assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
  a_read_unmapped:
    assert property (reg_rd && reg_addr[1] |=> reg_rdata == 8'h00) else $error("unmapped read");
  a_hold_starts:
    assert property (pwm_off_start && ok |-> ##[1:3] min_off_hold) else $error("hold did not start");
  a_hold_length:
    assert property ($fell(min_off_hold) |-> run_q == len_q) else $error("hold length wrong");
endmodule : mpo_props
bind mpo_top mpo_props u_props (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .compare_pwm, .core_event, .core_mode, .pwm_off_start, .phase_u_pulse_pin, .phase_v_pulse_pin,
  .phase_w_pulse_pin, .commutation_demag_monitor_pin, .zero_cross_monitor_pin, .min_off_hold);
`default_nettype wire

/* File: tb/mpo_stage.sv */
`timescale 1ns/1ps
`default_nettype none
module mpo_stage (
  // Clock and phase pins
  input wire logic ref_clk,
  input wire logic phase_u_pulse_pin,
  input wire logic phase_v_pulse_pin,
  input wire logic phase_w_pulse_pin,
  // Cycles with any phase switched on
  output var int   on_cnt
);
  initial on_cnt = 0;
  always @(posedge ref_clk) begin
    if (phase_u_pulse_pin || phase_v_pulse_pin || phase_w_pulse_pin) on_cnt <= on_cnt + 1;
  end
endmodule : mpo_stage
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb;
  logic                       ref_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic                       pwm_off_start = 1'b0, rnd = 1'b0, ok;
  logic [mpo_pkg::ADDR_W-1:0] reg_addr = '0;
  logic [7:0]                 reg_wdata = 8'h00, reg_rdata, m_ctl = 8'h00, e_rd;
  logic                       phase_u_pulse_pin, phase_v_pulse_pin, phase_w_pulse_pin, min_off_hold;
  logic                       commutation_demag_monitor_pin, zero_cross_monitor_pin, e_cd, e_zc, e_hold;
  logic [2:0]                 e_ph = 3'h0;
  mpo_pkg::mpo_phase_t        compare_pwm = '0;
  mpo_pkg::mpo_event_t        core_event = '0;
  mpo_pkg::mpo_mode_t         core_mode = '0;
  int                         fail_count = 0, comparisons = 0, cyc = 0, m_on = 0, rem = 0, n, on_cnt;
  always #10 ref_clk = ~ref_clk;
  mpo_top uut (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .compare_pwm,
    .core_event, .core_mode, .pwm_off_start, .phase_u_pulse_pin, .phase_v_pulse_pin, .phase_w_pulse_pin,
    .commutation_demag_monitor_pin, .zero_cross_monitor_pin, .min_off_hold);
  mpo_stage stage (.ref_clk, .phase_u_pulse_pin, .phase_v_pulse_pin, .phase_w_pulse_pin, .on_cnt);
  // ----------------------------------------
  // Reference model, checked just after each edge
  // ----------------------------------------
  always @(posedge ref_clk) begin
    ok = !core_mode.sensor_mode_select && !core_mode.on_time_sampling_enable
         && core_mode.on_time_sample_delay == 4'h0;
    if (e_ph != 3'h0) m_on++;
    e_ph = compare_pwm & m_ctl[6:4];
    e_cd = m_ctl[7] && (core_mode.speed_measure_mode ? core_event.commutation
           : core_mode.switched_mode && (core_event.commutation || core_event.demag));
    e_zc = m_ctl[7] && (core_mode.speed_measure_mode ? core_event.speed_capture
           : core_mode.switched_mode && core_event.zero_cross);
    e_hold = rem > 0;
    e_rd = !reg_rd ? 8'h00 : (reg_addr == 2'h0) ? m_ctl : (reg_addr == 2'h1) ? {6'h00, ok, e_hold} : 8'h00;
    if (!ok) rem = 0;
    else if (pwm_off_start) rem = 125 * (m_ctl[3:0] + 1);
    else if (rem > 0) rem--;
    if (reg_wr && reg_addr == 2'h0) m_ctl = reg_wdata;
    #1;
    if (reset_n) begin
      `CHK({phase_w_pulse_pin, phase_v_pulse_pin, phase_u_pulse_pin}, e_ph)
      `CHK({commutation_demag_monitor_pin, zero_cross_monitor_pin}, {e_cd, e_zc})
      `CHK(reg_rdata, e_rd)
      `CHK(min_off_hold, e_hold)
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (rnd) compare_pwm <= 3'($urandom);
    if (rnd) core_event <= 4'($urandom);
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [1:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask : rd
  task automatic start_off();
    pwm_off_start <= 1'b1;
    @(posedge ref_clk);
    pwm_off_start <= 1'b0;
  endtask : start_off
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(32'h9501688a));
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd(2'h0);
    rnd <= 1'b1;
    // Every route and debug setting against every mode pair.
    for (int i = 0; i < 64; i++) begin
      core_mode <= {i[1:0], 6'h00};
      wr(2'h0, {i[5:2], 4'($urandom)});
      repeat (8) @(posedge ref_clk);
      rd(2'h0);
    end
    // Writes elsewhere must leave the control byte alone.
    for (int a = 1; a < 4; a++) wr(a[1:0], 8'hff);
    for (int a = 0; a < 4; a++) rd(a[1:0]);
    core_mode <= '0;
    for (int k = 0; k < 3; k++) begin
      n = (k == 0) ? 0 : (k == 1) ? 8 : 15;
      wr(2'h0, n[7:0]);
      start_off();
      rd(2'h1);
      repeat (125 * (n + 1) + 4) @(posedge ref_clk);
    end
    // Sensor mode, on-time sampling and a sampling delay each block the hold.
    for (int j = 0; j < 3; j++) begin
      core_mode <= (j == 0) ? 8'h20 : (j == 1) ? 8'h10 : 8'h05;
      @(posedge ref_clk);
      start_off();
      rd(2'h1);
      repeat (20) @(posedge ref_clk);
    end
    #2;
    `CHK(on_cnt, m_on)
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
